// ---- inc/qrw_pkg.sv ----
// qrw_pkg: shared opcodes, field positions and timing for the quad read front end
package qrw_pkg;
  // --------------------------------------------------------------------------
  // opcodes
  // --------------------------------------------------------------------------
  localparam logic [7:0] OP_WORD_READ  = 8'h00_E7;
  localparam logic [7:0] OP_OCTAL_READ = 8'h00_E3;
  localparam logic [7:0] OP_SET_WRAP   = 8'h00_77;
  localparam logic [7:0] OP_RST_EN     = 8'h00_66;
  localparam logic [7:0] OP_RST        = 8'h00_99;
  localparam logic [7:0] OP_PD         = 8'h00_B9;
  localparam logic [7:0] OP_PD_REL     = 8'h00_AB;
  localparam logic [7:0] OP_CRM_RESET  = 8'h00_FF;
  // --------------------------------------------------------------------------
  // field positions and counts
  // --------------------------------------------------------------------------
  localparam int          WRAP_DIS_POS   = 4;
  localparam int          WRAP_LEN_LO    = 5;
  localparam int          CRM_SEL_LO     = 4;
  localparam logic [1:0]  CRM_KEEP       = 2'h0_2;
  localparam logic [2:0]  WRAP_RESET_VAL = 3'h0_1;
  localparam int          OPCODE_BITS    = 8;
  localparam int          ADDR_NIBBLES   = 6;
  localparam int          MODE_NIBBLES   = 2;
  localparam int          WORD_DUMMY     = 2;
  localparam int          WRAP_DUMMY_BITS = 24;
  localparam int          WRAP_BYTE_BITS = 8;
  localparam logic [23:0] WORD_ALIGN_MASK  = 24'h00_0001;
  localparam logic [23:0] OCTAL_ALIGN_MASK = 24'h00_000F;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int RESET_HOLD_NS   = 40;
  localparam int RESET_REC_NS    = 30000;
  localparam int PD_ENTRY_NS     = 3000;
  localparam int PD_RELEASE_NS   = 3000;
  localparam int RESET_HOLD_CYC  = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_REC_CYC   = (RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PD_ENTRY_CYC    = PD_ENTRY_NS / CLK_PERIOD_NS;
  localparam int PD_RELEASE_CYC  = (PD_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_DIV        = 8;
endpackage

// ---- inc/qrw_if.sv ----
// qrw_if: serial link between host controller and flash command front end
`timescale 1ns/1ps
interface qrw_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;
  // --------------------------------------------------------------------------
  // wire level from enables, pulled high when nobody drives
  // --------------------------------------------------------------------------
  genvar g;
  for (g = 0; g < 4; g++) begin : g_io
    assign io[g] = host_io_oe[g] ? host_io_o[g] : (dev_io_oe[g] ? dev_io_o[g] : 1'b1);
  end
  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
  modport dev  (input cs_n, input sclk, output dev_io_o, output dev_io_oe, input io);
endinterface

// ---- logic/qrw_host.sv ----
// qrw_host: host controller end, issues one serial transaction per request
`timescale 1ns/1ps
module qrw_host (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  qrw_if.host              lnk,
  input  wire logic        i_req,
  input  wire logic [7:0]  i_opcode,
  input  wire logic        i_skip_opcode,
  input  wire logic        i_quad_addr,
  input  wire logic [23:0] i_addr,
  input  wire logic [7:0]  i_mode,
  input  wire logic [7:0]  i_nread,
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid
);
  typedef enum logic [2:0] {H_IDLE, H_OP, H_ADDR, H_MODE, H_TURN, H_READ, H_END} qrw_hst_t;
  qrw_hst_t    st_ff;
  logic [2:0]  div_ff;
  logic        sclk_ff;
  logic        cs_n_ff;
  logic [31:0] sh_ff;
  logic [7:0]  cnt_ff;
  logic [7:0]  nread_ff;
  logic [7:0]  op_ff;
  logic        quad_ff;
  logic [3:0]  io_ff;
  logic [3:0]  oe_ff;
  logic [7:0]  rd_ff;
  logic        rv_ff;
  logic        done_ff;
  logic [3:0]  turn_ff;
  logic        rise;
  logic        fall;
  // --------------------------------------------------------------------------
  // link clock divider, host makes sclk
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || cs_n_ff) begin
      div_ff  <= '0;
      sclk_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 3'd1;
      if (div_ff == 3'(qrw_pkg::HOST_DIV / 2 - 1)) begin
        div_ff  <= '0;
        sclk_ff <= ~sclk_ff;
      end
    end
  end
  assign rise = !cs_n_ff && div_ff == 3'(qrw_pkg::HOST_DIV / 2 - 1) && !sclk_ff;
  assign fall = !cs_n_ff && div_ff == 3'(qrw_pkg::HOST_DIV / 2 - 1) && sclk_ff;
  // --------------------------------------------------------------------------
  // transaction sequencer, drives on falling edges, samples on rising
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_ff <= H_IDLE;
      cs_n_ff <= 1'b1;
      sh_ff <= '0;
      cnt_ff <= '0;
      nread_ff <= '0;
      op_ff <= '0;
      quad_ff <= 1'b0;
      io_ff <= '0;
      oe_ff <= '0;
      rd_ff <= '0;
      rv_ff <= 1'b0;
      done_ff <= 1'b0;
      turn_ff <= '0;
    end else begin
      rv_ff <= 1'b0;
      done_ff <= 1'b0;
      unique case (st_ff)
        H_IDLE: if (i_req) begin
          cs_n_ff <= 1'b0;
          op_ff <= i_opcode;
          quad_ff <= i_quad_addr;
          nread_ff <= i_nread;
          // octal read streams straight after the mode bits, word read waits two rises
          turn_ff <= (i_opcode == qrw_pkg::OP_OCTAL_READ) ? 4'h0 : 4'(qrw_pkg::WORD_DUMMY);
          sh_ff <= {i_addr, i_mode};
          oe_ff <= 4'h0_1;
          if (i_skip_opcode) begin
            st_ff <= H_ADDR;
            oe_ff <= 4'h0_F;
            io_ff <= i_addr[23:20];
            sh_ff <= {i_addr[19:0], i_mode, 4'h0_0};
            cnt_ff <= 8'(qrw_pkg::ADDR_NIBBLES + qrw_pkg::MODE_NIBBLES - 1);
          end else begin
            st_ff <= H_OP;
            io_ff <= {3'h0_0, i_opcode[7]};
            op_ff <= {i_opcode[6:0], 1'b0};
            cnt_ff <= 8'(qrw_pkg::OPCODE_BITS - 1);
          end
        end
        H_OP: if (fall) begin
          if (cnt_ff == 8'h00_00) begin
            if (nread_ff == 8'h00_00 && !quad_ff) begin
              st_ff <= H_END;
            end else if (quad_ff) begin
              st_ff <= H_ADDR;
              oe_ff <= 4'h0_F;
              io_ff <= sh_ff[31:28];
              sh_ff <= {sh_ff[27:0], 4'h0_0};
              cnt_ff <= 8'(qrw_pkg::ADDR_NIBBLES + qrw_pkg::MODE_NIBBLES - 1);
            end else begin
              st_ff <= H_MODE;
              io_ff <= {3'h0_0, sh_ff[31]};
              sh_ff <= {sh_ff[30:0], 1'b0};
              cnt_ff <= 8'(qrw_pkg::WRAP_DUMMY_BITS + qrw_pkg::WRAP_BYTE_BITS - 1);
            end
          end else begin
            cnt_ff <= cnt_ff - 8'd1;
            io_ff <= {3'h0_0, op_ff[7]};
            op_ff <= {op_ff[6:0], 1'b0};
          end
        end
        H_ADDR: if (fall) begin
          if (cnt_ff == 8'h00_00) begin
            st_ff <= (nread_ff == 8'h00_00) ? H_END : H_TURN;
            oe_ff <= '0;
            cnt_ff <= 8'd1;
          end else begin
            cnt_ff <= cnt_ff - 8'd1;
            io_ff <= sh_ff[31:28];
            sh_ff <= {sh_ff[27:0], 4'h0_0};
          end
        end
        H_MODE: if (fall) begin
          if (cnt_ff == 8'h00_00) begin
            st_ff <= H_END;
          end else begin
            cnt_ff <= cnt_ff - 8'd1;
            io_ff <= {3'h0_0, sh_ff[31]};
            sh_ff <= {sh_ff[30:0], 1'b0};
          end
        end
        H_TURN: begin
          // io released at end of mode bits, before device first drives
          st_ff <= H_READ;
          cnt_ff <= 8'd1;
        end
        H_READ: if (rise) begin
          if (turn_ff != 4'h0) begin
            // dummy rises carry nothing from the flash
            turn_ff <= turn_ff - 4'd1;
          end else begin
            rd_ff <= {rd_ff[3:0], lnk.io};
            if (cnt_ff == 8'h00_00) begin
              rv_ff <= 1'b1;
              cnt_ff <= 8'd1;
              nread_ff <= nread_ff - 8'd1;
              if (nread_ff == 8'd1) st_ff <= H_END;
            end else begin
              cnt_ff <= cnt_ff - 8'd1;
            end
          end
        end
        H_END: if (!sclk_ff) begin
          cs_n_ff <= 1'b1;
          oe_ff <= '0;
          done_ff <= 1'b1;
          st_ff <= H_IDLE;
        end
      endcase
    end
  end
  assign lnk.cs_n = cs_n_ff;
  assign lnk.sclk = sclk_ff;
  assign lnk.host_io_o = io_ff;
  assign lnk.host_io_oe = oe_ff;
  assign o_busy = st_ff != H_IDLE;
  assign o_done = done_ff;
  assign o_rdata = rd_ff;
  assign o_rvalid = rv_ff;
endmodule

// ---- logic/qrw_dev.sv ----
// qrw_dev: flash command front end for quad reads, wrap, reset and power-down
`timescale 1ns/1ps
module qrw_dev (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  qrw_if.dev               lnk,
  input  wire logic        i_quad_enable_bit,
  output logic [23:0]      o_rd_addr,
  output logic             o_rd_req,
  input  wire logic [7:0]  i_rd_data,
  output logic             o_soft_reset,
  output logic             o_powered_down,
  output logic [2:0]       o_wrap_setting_bits,
  output logic             o_continuous_read
);
  typedef enum logic [2:0] {D_OP, D_ADDR, D_MODE, D_DUMMY, D_DATA, D_WRAP, D_IGNORE} qrw_dst_t;
  qrw_dst_t    st_ff;
  logic [2:0]  cs_sync_ff;
  logic [2:0]  clk_sync_ff;
  logic [3:0]  io_s1_ff;
  logic [3:0]  io_s2_ff;
  logic        rise;
  logic        fall;
  logic        cs_rise;
  logic [31:0] sh_ff;
  logic [5:0]  cnt_ff;
  logic [7:0]  op_ff;
  logic [23:0] addr_ff;
  logic [7:0]  mode_ff;
  logic [2:0]  wrap_ff;
  logic        rst_en_ff;
  logic        rst_arm_ff;
  logic [3:0]  hold_ff;
  logic [15:0] tmr_ff;
  logic        pd_ff;
  logic        pd_pend_ff;
  logic        rel_pend_ff;
  logic        pd_arm_ff;
  logic        rel_arm_ff;
  logic [7:0]  dout_ff;
  logic        nib_ff;
  logic [3:0]  oe_ff;
  logic [3:0]  do_ff;
  logic        srst_ff;
  logic [23:0] nxt_addr;
  logic [5:0]  wmask;
  logic        crm;
  assign crm = mode_ff[qrw_pkg::CRM_SEL_LO +: 2] == qrw_pkg::CRM_KEEP;
  // --------------------------------------------------------------------------
  // pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cs_sync_ff <= 3'h0_7;
      clk_sync_ff <= '0;
      io_s1_ff <= '0;
      io_s2_ff <= '0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], lnk.cs_n};
      clk_sync_ff <= {clk_sync_ff[1:0], lnk.sclk};
      io_s1_ff <= lnk.io;
      io_s2_ff <= io_s1_ff;
    end
  end
  assign rise = !cs_sync_ff[1] && clk_sync_ff[1] && !clk_sync_ff[2];
  assign fall = !cs_sync_ff[1] && !clk_sync_ff[1] && clk_sync_ff[2];
  assign cs_rise = cs_sync_ff[1] && !cs_sync_ff[2];
  // --------------------------------------------------------------------------
  // wrap-aware address advance
  // --------------------------------------------------------------------------
  assign wmask = 6'((8 << wrap_ff[2:1]) - 1);
  always_comb begin
    nxt_addr = addr_ff + 24'd1;
    if (!wrap_ff[0]) begin
      nxt_addr = {addr_ff[23:6], (addr_ff[5:0] & ~wmask) | ((addr_ff[5:0] + 6'd1) & wmask)};
    end
  end
  // --------------------------------------------------------------------------
  // command decoder and transfer sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || srst_ff) begin
      st_ff <= D_OP;
      sh_ff <= '0;
      cnt_ff <= '0;
      op_ff <= '0;
      addr_ff <= '0;
      mode_ff <= '0;
      wrap_ff <= qrw_pkg::WRAP_RESET_VAL;
      rst_en_ff <= 1'b0;
      rst_arm_ff <= 1'b0;
      pd_arm_ff <= 1'b0;
      rel_arm_ff <= 1'b0;
      dout_ff <= '0;
      nib_ff <= 1'b0;
      oe_ff <= '0;
      do_ff <= '0;
    end else if (cs_rise || cs_sync_ff[1]) begin
      oe_ff <= '0;
      cnt_ff <= '0;
      rst_arm_ff <= 1'b0;
      pd_arm_ff <= 1'b0;
      rel_arm_ff <= 1'b0;
      nib_ff <= 1'b0;
      if (cs_rise && st_ff == D_OP && cnt_ff == 6'd0 && op_ff == qrw_pkg::OP_RST_EN && !rst_arm_ff)
        rst_en_ff <= rst_en_ff;
      // next frame starts at address if mode kept opcode skip
      st_ff <= (crm && !pd_ff) ? D_ADDR : D_OP;
      if (crm) cnt_ff <= 6'(qrw_pkg::ADDR_NIBBLES);
    end else begin
      unique case (st_ff)
        D_OP: if (rise) begin
          op_ff <= {op_ff[6:0], io_s2_ff[0]};
          cnt_ff <= cnt_ff + 6'd1;
          if (cnt_ff == 6'(qrw_pkg::OPCODE_BITS - 1)) begin
            st_ff <= D_IGNORE;
            rst_en_ff <= 1'b0;
            if (pd_ff || pd_pend_ff) begin
              rel_arm_ff <= {op_ff[6:0], io_s2_ff[0]} == qrw_pkg::OP_PD_REL;
            end else begin
              unique case ({op_ff[6:0], io_s2_ff[0]})
                qrw_pkg::OP_WORD_READ, qrw_pkg::OP_OCTAL_READ: if (i_quad_enable_bit) begin
                  st_ff <= D_ADDR;
                  cnt_ff <= 6'(qrw_pkg::ADDR_NIBBLES);
                end
                qrw_pkg::OP_SET_WRAP: if (i_quad_enable_bit) begin
                  st_ff <= D_WRAP;
                  cnt_ff <= 6'(qrw_pkg::WRAP_DUMMY_BITS + qrw_pkg::WRAP_BYTE_BITS);
                end
                qrw_pkg::OP_RST_EN: rst_en_ff <= !rel_pend_ff;
                qrw_pkg::OP_RST: rst_arm_ff <= rst_en_ff && !crm;
                qrw_pkg::OP_PD: pd_arm_ff <= 1'b1;
                qrw_pkg::OP_CRM_RESET: mode_ff <= '0;
                default: ;
              endcase
            end
          end
        end
        D_ADDR: if (rise) begin
          addr_ff <= {addr_ff[19:0], io_s2_ff};
          cnt_ff <= cnt_ff - 6'd1;
          if (cnt_ff == 6'd1) begin
            st_ff <= D_MODE;
            cnt_ff <= 6'(qrw_pkg::MODE_NIBBLES);
          end
        end
        D_MODE: if (rise) begin
          mode_ff <= {mode_ff[3:0], io_s2_ff};
          cnt_ff <= cnt_ff - 6'd1;
          if (cnt_ff == 6'd1) begin
            // word read needs A0 clear, octal read A3..A0 clear
            if (op_ff == qrw_pkg::OP_OCTAL_READ) begin
              addr_ff <= addr_ff & ~qrw_pkg::OCTAL_ALIGN_MASK;
              st_ff <= D_DATA;
              cnt_ff <= 6'd0;
            end else begin
              addr_ff <= addr_ff & ~qrw_pkg::WORD_ALIGN_MASK;
              st_ff <= D_DUMMY;
              cnt_ff <= 6'(qrw_pkg::WORD_DUMMY);
            end
          end
        end
        D_DUMMY: if (rise) begin
          cnt_ff <= cnt_ff - 6'd1;
          if (cnt_ff == 6'd1) st_ff <= D_DATA;
        end
        D_DATA: if (fall) begin
          // high nibble first; next byte fetched while low nibble is out
          oe_ff <= 4'h0_F;
          nib_ff <= ~nib_ff;
          if (!nib_ff) begin
            do_ff <= i_rd_data[7:4];
            dout_ff <= i_rd_data;
          end else begin
            do_ff <= dout_ff[3:0];
            addr_ff <= nxt_addr;
          end
        end
        D_WRAP: if (rise) begin
          sh_ff <= {sh_ff[30:0], io_s2_ff[0]};
          cnt_ff <= cnt_ff - 6'd1;
          if (cnt_ff == 6'd1) begin
            wrap_ff <= sh_ff[qrw_pkg::WRAP_DIS_POS - 1 +: 3]; // last bit not in yet
            st_ff <= D_IGNORE;
          end
        end
        D_IGNORE: if (rise) begin
          rst_arm_ff <= 1'b0;
          pd_arm_ff <= 1'b0;
          rel_arm_ff <= 1'b0;
        end
      endcase
    end
  end
  // --------------------------------------------------------------------------
  // reset hold, recovery and power-down timing
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      hold_ff <= '0;
      tmr_ff <= '0;
      pd_ff <= 1'b0;
      pd_pend_ff <= 1'b0;
      rel_pend_ff <= 1'b0;
      srst_ff <= 1'b0;
    end else begin
      srst_ff <= 1'b0;
      if (!rst_arm_ff) hold_ff <= '0;
      else if (hold_ff != 4'(qrw_pkg::RESET_HOLD_CYC - 1)) hold_ff <= hold_ff + 4'd1; // lags arm
      if (cs_rise && rst_arm_ff && hold_ff == 4'(qrw_pkg::RESET_HOLD_CYC - 1)) begin
        srst_ff <= 1'b1;
        tmr_ff <= 16'(qrw_pkg::RESET_REC_CYC);
      end else if (cs_rise && pd_arm_ff) begin
        pd_pend_ff <= 1'b1;
        tmr_ff <= 16'(qrw_pkg::PD_ENTRY_CYC);
      end else if (cs_rise && rel_arm_ff) begin
        pd_ff <= 1'b0;
        pd_pend_ff <= 1'b0;
        rel_pend_ff <= 1'b1;
        tmr_ff <= 16'(qrw_pkg::PD_RELEASE_CYC);
      end else if (tmr_ff != 16'd0) begin
        tmr_ff <= tmr_ff - 16'd1;
      end else begin
        if (pd_pend_ff) pd_ff <= 1'b1;
        pd_pend_ff <= 1'b0;
        rel_pend_ff <= 1'b0;
      end
    end
  end
  assign lnk.dev_io_o = do_ff;
  assign lnk.dev_io_oe = oe_ff;
  assign o_rd_addr = addr_ff;
  assign o_rd_req = st_ff == D_DATA && fall && !nib_ff;
  assign o_soft_reset = srst_ff;
  assign o_powered_down = pd_ff;
  assign o_wrap_setting_bits = wrap_ff;
  assign o_continuous_read = crm;
endmodule

// ---- sim/qrw_properties.sv ----
// qrw_properties: link-level checks on the host-to-flash serial interface
`timescale 1ns/1ps
module qrw_properties (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ---------------------------------------------------------------------------
  // turnaround and output drive
  // ---------------------------------------------------------------------------
  property p_no_fight;
    (host_io_oe & dev_io_oe) == 4'h0;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("host and flash drive io together");
  property p_quad_out;
    dev_io_oe != 4'h0 |-> dev_io_oe == 4'hF;
  endproperty
  a_quad_out: assert property (p_quad_out) else $error("flash drives part of the io lines");
  property p_rise_stable;
    $rose(sclk) && dev_io_oe == 4'hF |-> $stable(dev_io_o);
  endproperty
  a_rise_stable: assert property (p_rise_stable) else $error("flash data moved at sclk rise");
  // lag allows for the two-stage sync of chip select
  property p_release;
    $rose(cs_n) |-> ##[0:6] dev_io_oe == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("flash kept io after deselect");
  property p_host_quiet;
    cs_n && $past(cs_n, 2) |-> host_io_oe == 4'h0;
  endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("host drives io while idle");
  // ---------------------------------------------------------------------------
  // clock and framing
  // ---------------------------------------------------------------------------
  property p_idle_sclk;
    cs_n && $past(cs_n) |-> !sclk;
  endproperty
  a_idle_sclk: assert property (p_idle_sclk) else $error("sclk not low between frames");
  property p_sclk_half;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase not four cycles");
  property p_cs_gap;
    $rose(cs_n) |-> cs_n [*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("chip select high under one sclk period");
endmodule

// ---- sim/qrw_bench.sv ----
// qrw_bench: host and flash ends joined, reads checked against a byte model
`timescale 1ns/1ps
module qrw_bench;
  logic        i_mclk  = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        req     = 1'b0;
  logic        skip    = 1'b0;
  logic        quad    = 1'b0;
  logic        qe      = 1'b1;
  logic [7:0]  op      = 8'h00_00;
  logic [7:0]  mode    = 8'h00_00;
  logic [7:0]  nrd     = 8'h00_00;
  logic [23:0] addr    = 24'h00_0000;
  logic [23:0] rad;
  logic [7:0]  rdat;
  logic [7:0]  hdat;
  logic        done;
  logic        rv;
  logic        srst;
  logic        pd;
  logic        crm;
  logic [2:0]  wrap;
  logic [7:0]  got [$];
  int          failures = 0;
  int          check_count = 0;
  int          seed = 11;
  int          nsr = 0;
  int          wm = 1;
  int          len;
  qrw_if lnk ();
  qrw_host i_qrw_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .lnk(lnk), .i_req(req),
    .i_opcode(op), .i_skip_opcode(skip), .i_quad_addr(quad), .i_addr(addr), .i_mode(mode),
    .i_nread(nrd), .o_busy(), .o_done(done), .o_rdata(hdat), .o_rvalid(rv));
  qrw_dev i_qrw_dev (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .lnk(lnk), .i_quad_enable_bit(qe),
    .o_rd_addr(rad), .o_rd_req(), .i_rd_data(rdat), .o_soft_reset(srst),
    .o_powered_down(pd), .o_wrap_setting_bits(wrap), .o_continuous_read(crm));
  qrw_properties i_qrw_properties (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .host_io_oe(lnk.host_io_oe), .dev_io_o(lnk.dev_io_o),
    .dev_io_oe(lnk.dev_io_oe));
  always #4 i_mclk = ~i_mclk;
  // ---------------------------------------------------------------------------
  // memory model and monitors
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h00_3C;
  endfunction
  assign rdat = mem(rad);
  always @(negedge i_mclk) begin
    if (rv === 1'b1) got.push_back(hdat);
    if (srst === 1'b1) nsr++;
  end
  // ---------------------------------------------------------------------------
  // compare, report and transfer tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_state(input logic [3:0] g, input logic [3:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic frame(input logic [7:0] o, input logic s, input logic q, input logic [23:0] a,
                       input logic [7:0] m, input logic [7:0] n);
    int k;
    got.delete();
    @(negedge i_mclk);
    op = o;
    skip = s;
    quad = q;
    addr = a;
    mode = m;
    nrd = n;
    req = 1'b1;
    @(negedge i_mclk);
    req = 1'b0;
    for (k = 0; k < 8000 && done !== 1'b1; k++) @(negedge i_mclk);
    if (k == 8000) begin
      failures++;
      close_out();
    end
    idle(12);
  endtask
  // expected addresses follow the wrap model, linear when the disable bit is set
  task automatic rd(input logic [7:0] o, input logic s, input logic [23:0] a,
                    input logic [7:0] m, input int n);
    int i;
    int l;
    int ea;
    frame(o, s, 1'b1, a, m, 8'(n));
    l = 8 << ((wm >> 1) & 3);
    chk_byte(8'(got.size()), 8'(n));
    for (i = 0; i < n; i++) begin
      ea = wm[0] ? a + i : (a & ~(l - 1)) | ((a + i) & (l - 1));
      chk_byte(got[i], mem(24'(ea)));
    end
  endtask
  function automatic logic [23:0] ra(input logic [23:0] msk);
    return 24'($random(seed)) & msk;
  endfunction
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(negedge i_mclk);
    i_rst_n = 1'b1;
    idle(2);
    chk_state({1'b0, wrap}, 4'h1);
    chk_state({3'h0, pd}, 4'h0);
    $display("test reset defaults done");
    rd(qrw_pkg::OP_WORD_READ, 1'b0, ra(24'hFF_FFFE), 8'h00_00, 5);
    rd(qrw_pkg::OP_OCTAL_READ, 1'b0, ra(24'hFF_FFF0), 8'h00_0F, 5);
    chk_state({3'h0, crm}, 4'h0);
    $display("test linear reads done");
    for (len = 0; len < 4; len++) begin
      frame(qrw_pkg::OP_SET_WRAP, 1'b0, 1'b0, 24'h00_0000,
            (8'($random(seed)) & 8'h00_8F) | 8'(len << 5), 8'h00_01);
      wm = len * 2;
      chk_state({1'b0, wrap}, 4'(wm));
      rd(qrw_pkg::OP_WORD_READ, 1'b0, ra(24'hFF_FFFE), 8'h00_00, (8 << len) + 3);
    end
    qe = 1'b0;
    frame(qrw_pkg::OP_SET_WRAP, 1'b0, 1'b0, 24'h00_0000, 8'h00_10, 8'h00_01);
    chk_state({1'b0, wrap}, 4'(wm));
    qe = 1'b1;
    $display("test wrap done");
    rd(qrw_pkg::OP_WORD_READ, 1'b0, ra(24'hFF_FFFE), 8'h00_2A, 4);
    chk_state({3'h0, crm}, 4'h1);
    rd(qrw_pkg::OP_WORD_READ, 1'b1, ra(24'hFF_FFFE), 8'h00_25, 4);
    frame(qrw_pkg::OP_RST_EN, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    frame(qrw_pkg::OP_RST, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    idle(qrw_pkg::RESET_HOLD_CYC + 8);
    chk_state(4'(nsr), 4'h0);
    // 66h fell into the address and mode slots; mode bits 5:4 came in as 11, which left continuous mode
    chk_state({3'h0, crm}, 4'h0);
    rd(qrw_pkg::OP_WORD_READ, 1'b0, ra(24'hFF_FFFE), 8'h00_2F, 2);
    rd(qrw_pkg::OP_WORD_READ, 1'b1, ra(24'hFF_FFFE), 8'h00_00, 2);
    chk_state({3'h0, crm}, 4'h0);
    rd(qrw_pkg::OP_WORD_READ, 1'b0, ra(24'hFF_FFFE), 8'h00_2F, 2);
    frame(qrw_pkg::OP_CRM_RESET, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    chk_state({3'h0, crm}, 4'h0);
    $display("test continuous read done");
    frame(qrw_pkg::OP_RST_EN, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    frame(qrw_pkg::OP_PD_REL, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    frame(qrw_pkg::OP_RST, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    chk_state(4'(nsr), 4'h0);
    frame(qrw_pkg::OP_RST_EN, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    frame(qrw_pkg::OP_RST, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    idle(qrw_pkg::RESET_REC_CYC);
    chk_state(4'(nsr), 4'h1);
    wm = 1;
    chk_state({1'b0, wrap}, 4'h1);
    rd(qrw_pkg::OP_WORD_READ, 1'b0, ra(24'hFF_FFFE), 8'h00_00, 9);
    $display("test soft reset done");
    frame(qrw_pkg::OP_PD, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    idle(qrw_pkg::PD_ENTRY_CYC);
    chk_state({3'h0, pd}, 4'h1);
    frame(qrw_pkg::OP_SET_WRAP, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_01);
    chk_state({1'b0, wrap}, 4'h1);
    frame(qrw_pkg::OP_RST_EN, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    frame(qrw_pkg::OP_RST, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    idle(qrw_pkg::RESET_HOLD_CYC + 8);
    chk_state(4'(nsr), 4'h1);
    frame(qrw_pkg::OP_PD_REL, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    idle(qrw_pkg::PD_RELEASE_CYC + 4);
    chk_state({3'h0, pd}, 4'h0);
    frame(qrw_pkg::OP_RST_EN, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    frame(qrw_pkg::OP_RST, 1'b0, 1'b0, 24'h00_0000, 8'h00_00, 8'h00_00);
    idle(qrw_pkg::RESET_REC_CYC);
    chk_state(4'(nsr), 4'h2);
    $display("test power-down done");
    close_out();
  end
endmodule
